// >>> design/ebps_pkg.sv
// shared constants for the external bus pin select block
package ebps_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] EBPS_OFF_MODE = 8'h00;
    localparam logic [7:0] EBPS_OFF_HADDR = 8'h04;
    localparam logic [7:0] EBPS_OFF_PDAT = 8'h08;
    localparam logic [7:0] EBPS_OFF_PDIR = 8'h0C;
    localparam logic [7:0] EBPS_OFF_PULL = 8'h10;
    localparam logic [7:0] EBPS_OFF_PIN = 8'h14;
    localparam logic [7:0] EBPS_OFF_STAT = 8'h18;
    // ========================================
    // mode register fields
    localparam int EBPS_MODE_EXTBUS = 0;
    localparam int EBPS_MODE_BUS16 = 1;
    localparam int EBPS_MODE_LO_OE = 2;
    localparam int EBPS_MODE_HI_OE = 3;
    localparam int EBPS_MODE_STBY = 4;
    localparam int EBPS_MODE_W = 5;
    // ========================================
    // pin vector layout: 0..3 port2 upper, 4 latch, 5 read, 6 low strobe, 7 high strobe
    localparam int EBPS_NPIN = 8;
    localparam int EBPS_PIN_ALE = 4;
    localparam int EBPS_PIN_RD = 5;
    localparam int EBPS_PIN_LO_STB = 6;
    localparam int EBPS_PIN_HI_STB = 7;
    localparam logic [3:0] EBPS_HADDR_RST = 4'h0;
    localparam logic [EBPS_MODE_W-1:0] EBPS_MODE_RST = 5'h00;
    localparam logic [31:0] EBPS_RD_ZERO = 32'h00000000;
endpackage : ebps_pkg

// >>> design/ebps_apb_regs.sv
// apb slave register file for the pin select block
module ebps_apb_regs
    import ebps_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // register contents
    output logic [EBPS_MODE_W-1:0] mode_q,
    output logic [3:0] high_addr_output_ctrl_q,
    output logic [EBPS_NPIN-1:0] port_data_q,
    output logic [EBPS_NPIN-1:0] port_dir_q,
    output logic [EBPS_NPIN-1:0] pull_sel_q,
    // read-only state
    input wire logic [EBPS_NPIN-1:0] pin_sample,
    input wire logic [EBPS_NPIN-1:0] bus_owned
);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {EBPS_OFF_MODE, EBPS_OFF_HADDR, EBPS_OFF_PDAT, EBPS_OFF_PDIR,
                               EBPS_OFF_PULL, EBPS_OFF_PIN, EBPS_OFF_STAT};

    // ========================================
    // writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= EBPS_MODE_RST;
            high_addr_output_ctrl_q <= EBPS_HADDR_RST;
            port_data_q <= '0;
            port_dir_q <= '0;
            pull_sel_q <= '0;
        end else if (acc && pwrite) begin
            unique case (paddr)
                EBPS_OFF_MODE: mode_q <= pwdata[EBPS_MODE_W-1:0];
                EBPS_OFF_HADDR: high_addr_output_ctrl_q <= pwdata[3:0];
                EBPS_OFF_PDAT: port_data_q <= pwdata[EBPS_NPIN-1:0];
                EBPS_OFF_PDIR: port_dir_q <= pwdata[EBPS_NPIN-1:0];
                EBPS_OFF_PULL: pull_sel_q <= pwdata[EBPS_NPIN-1:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // reads and answer, zero wait state; unmapped gives pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= EBPS_RD_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= EBPS_RD_ZERO;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    EBPS_OFF_MODE: prdata <= {27'h0000000, mode_q};
                    EBPS_OFF_HADDR: prdata <= {28'h0000000, high_addr_output_ctrl_q};
                    EBPS_OFF_PDAT: prdata <= {24'h000000, port_data_q};
                    EBPS_OFF_PDIR: prdata <= {24'h000000, port_dir_q};
                    EBPS_OFF_PULL: prdata <= {24'h000000, pull_sel_q};
                    EBPS_OFF_PIN: prdata <= {24'h000000, pin_sample};
                    EBPS_OFF_STAT: prdata <= {24'h000000, bus_owned};
                    default: prdata <= EBPS_RD_ZERO;
                endcase
            end
        end
    end
endmodule : ebps_apb_regs

// >>> design/ebps_pin_cell.sv
// one shared pin: bus or port function, registered drive, input gating
module ebps_pin_cell (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selection
    input wire logic bus_sel,
    input wire logic bus_out,
    input wire logic port_out,
    input wire logic port_dir,
    input wire logic pull_sel,
    input wire logic standby,
    // pad
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pad_pull,
    output logic core_in
);
    // both mux legs settle in one flop, so a switchover never shows an intermediate value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 1'b1;
            pad_oe_n <= 1'b1;
            pad_pull <= 1'b0;
            core_in <= 1'b0;
        end else begin
            pad_out <= bus_sel ? bus_out : port_out;
            pad_oe_n <= bus_sel ? 1'b0 : !port_dir;
            pad_pull <= pull_sel && !bus_sel && !port_dir;
            core_in <= standby ? 1'b0 : pad_in;
        end
    end
endmodule : ebps_pin_cell

// >>> design/ebps_top.sv
// external bus pin select: chooses bus strobes/high address or port function per shared pin
// Contract
// - external bus, high address control bit 1: port2 upper pin is port
// - external bus, high address control bit 0: pin drives address lines 20 to 23
// - latch strobe on its pin only while external bus enabled
// - read strobe on its pin only while external bus enabled
// - low write strobe needs external bus and its pin enable
// - low strobe qualifies low byte in 16-bit, whole bus in 8-bit
// - high strobe needs external bus, 16-bit mode and its enable
// - low strobe pin is port in single-chip or when its output disabled
// - high strobe pin is port in single-chip or when its output disabled
// - latch and read pins are port pins in single-chip mode
// - software bit per pin selects pull-up on port input pins
// - inputs disconnected from core during standby
module ebps_top
    import ebps_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus controller side
    input wire logic [3:0] high_address_outputs,
    input wire logic ale_in,
    input wire logic rd_n_in,
    input wire logic wr_lo_n_in,
    input wire logic wr_hi_n_in,
    input wire logic bus_write,
    input wire logic bus_word,
    // pads
    input wire logic [EBPS_NPIN-1:0] pad_in,
    output logic [EBPS_NPIN-1:0] pad_out,
    output logic [EBPS_NPIN-1:0] pad_oe_n,
    output logic [EBPS_NPIN-1:0] pad_pull,
    // core side
    output logic [EBPS_NPIN-1:0] port_in,
    output logic [1:0] byte_lane_we
);
    logic [EBPS_MODE_W-1:0] mode_q;
    logic [3:0] high_addr_output_ctrl_q;
    logic [EBPS_NPIN-1:0] port_data_q;
    logic [EBPS_NPIN-1:0] port_dir_q;
    logic [EBPS_NPIN-1:0] pull_sel_q;
    logic [EBPS_NPIN-1:0] bus_sel;
    logic [EBPS_NPIN-1:0] bus_val;
    logic ext_bus;
    logic bus16;
    logic standby;

    assign ext_bus = mode_q[EBPS_MODE_EXTBUS];
    assign bus16 = mode_q[EBPS_MODE_BUS16];
    assign standby = mode_q[EBPS_MODE_STBY];

    ebps_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .mode_q(mode_q),
        .high_addr_output_ctrl_q(high_addr_output_ctrl_q),
        .port_data_q(port_data_q),
        .port_dir_q(port_dir_q),
        .pull_sel_q(pull_sel_q),
        .pin_sample(port_in),
        .bus_owned(bus_sel)
    );

    // ========================================
    // function selection per pin
    always_comb begin
        bus_sel[3:0] = {4{ext_bus}} & ~high_addr_output_ctrl_q;
        bus_sel[EBPS_PIN_ALE] = ext_bus;
        bus_sel[EBPS_PIN_RD] = ext_bus;
        bus_sel[EBPS_PIN_LO_STB] = ext_bus && mode_q[EBPS_MODE_LO_OE];
        bus_sel[EBPS_PIN_HI_STB] = ext_bus && bus16 && mode_q[EBPS_MODE_HI_OE];
        bus_val = {wr_hi_n_in, wr_lo_n_in, rd_n_in, ale_in, high_address_outputs};
    end

    genvar g;
    generate
        for (g = 0; g < EBPS_NPIN; g++) begin : g_pin
            ebps_pin_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .bus_sel(bus_sel[g]),
                .bus_out(bus_val[g]),
                .port_out(port_data_q[g]),
                .port_dir(port_dir_q[g]),
                .pull_sel(pull_sel_q[g]),
                .standby(standby),
                .pad_in(pad_in[g]),
                .pad_out(pad_out[g]),
                .pad_oe_n(pad_oe_n[g]),
                .pad_pull(pad_pull[g]),
                .core_in(port_in[g])
            );
        end
    endgenerate

    // ========================================
    // byte lanes written by a strobe: bit 0 low byte, bit 1 high byte
    // in 8-bit mode the low strobe covers the whole narrow bus, which is lane 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_lane_we <= 2'h0;
        end else begin
            byte_lane_we[0] <= bus_sel[EBPS_PIN_LO_STB] && bus_write && !wr_lo_n_in;
            byte_lane_we[1] <= bus_sel[EBPS_PIN_HI_STB] && bus_word && bus_write && !wr_hi_n_in;
        end
    end

    // ========================================
    // checks: every pad is registered, so each one is judged one edge after what it follows
    // ========================================
    // high address pins
    hi_addr_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && !high_addr_output_ctrl_q[0]) |=> (!pad_oe_n[0] && pad_out[0] == $past(high_address_outputs[0])))
        else $error("high address pin not driven by bus");
    hi_addr1_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && !high_addr_output_ctrl_q[1]) |=> (!pad_oe_n[1] && pad_out[1] == $past(high_address_outputs[1])))
        else $error("high address line 21 not driven");
    hi_addr2_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && !high_addr_output_ctrl_q[2]) |=> (!pad_oe_n[2] && pad_out[2] == $past(high_address_outputs[2])))
        else $error("high address line 22 not driven");
    hi_addr3_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && !high_addr_output_ctrl_q[3]) |=> (!pad_oe_n[3] && pad_out[3] == $past(high_address_outputs[3])))
        else $error("high address line 23 not driven");
    hi_addr_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        (high_addr_output_ctrl_q[1] || !ext_bus) |=> (pad_oe_n[1] == !$past(port_dir_q[1])))
        else $error("port2 upper pin not under port control");
    hi_port0_a: assert property (@(posedge pclk) disable iff (!presetn)
        (high_addr_output_ctrl_q[0] || !ext_bus) |=> (pad_oe_n[0] == !$past(port_dir_q[0])
            && pad_out[0] == $past(port_data_q[0])))
        else $error("port2 pin 0 not under port control");
    hi_port2_a: assert property (@(posedge pclk) disable iff (!presetn)
        (high_addr_output_ctrl_q[2] || !ext_bus) |=> (pad_oe_n[2] == !$past(port_dir_q[2])
            && pad_out[2] == $past(port_data_q[2])))
        else $error("port2 pin 2 not under port control");
    hi_port3_a: assert property (@(posedge pclk) disable iff (!presetn)
        (high_addr_output_ctrl_q[3] || !ext_bus) |=> (pad_oe_n[3] == !$past(port_dir_q[3])
            && pad_out[3] == $past(port_data_q[3])))
        else $error("port2 pin 3 not under port control");
    // ========================================
    // latch and read strobe pins
    latch_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_bus |=> (!pad_oe_n[EBPS_PIN_ALE] && pad_out[EBPS_PIN_ALE] == $past(ale_in)))
        else $error("latch strobe not on pin");
    read_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_bus |=> (pad_out[EBPS_PIN_RD] == $past(rd_n_in)))
        else $error("read strobe not on pin");
    read_pin_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_bus |=> !pad_oe_n[EBPS_PIN_RD])
        else $error("read strobe pin not driven");
    single_chip_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_bus |=> (pad_out[EBPS_PIN_RD] == $past(port_data_q[EBPS_PIN_RD])
            && pad_out[EBPS_PIN_ALE] == $past(port_data_q[EBPS_PIN_ALE])))
        else $error("strobe pin not port in single chip");
    single_chip_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_bus |=> (pad_oe_n[EBPS_PIN_RD] == !$past(port_dir_q[EBPS_PIN_RD])
            && pad_oe_n[EBPS_PIN_ALE] == !$past(port_dir_q[EBPS_PIN_ALE])))
        else $error("strobe pin direction not port in single chip");
    // ========================================
    // write strobe pins
    low_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && mode_q[EBPS_MODE_LO_OE]) |=> (pad_out[EBPS_PIN_LO_STB] == $past(wr_lo_n_in)))
        else $error("low write strobe not on pin");
    low_strobe_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && mode_q[EBPS_MODE_LO_OE]) |=> !pad_oe_n[EBPS_PIN_LO_STB])
        else $error("low write strobe pin not driven");
    low_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(ext_bus && mode_q[EBPS_MODE_LO_OE]) |=> (pad_out[EBPS_PIN_LO_STB] == $past(port_data_q[EBPS_PIN_LO_STB])))
        else $error("low strobe pin not port");
    low_port_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(ext_bus && mode_q[EBPS_MODE_LO_OE]) |=> (pad_oe_n[EBPS_PIN_LO_STB] == !$past(port_dir_q[EBPS_PIN_LO_STB])))
        else $error("low strobe pin direction not port");
    high_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && !bus16) |=> (pad_out[EBPS_PIN_HI_STB] == $past(port_data_q[EBPS_PIN_HI_STB])))
        else $error("high strobe out in 8-bit mode");
    high_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && bus16 && mode_q[EBPS_MODE_HI_OE]) |=> (!pad_oe_n[EBPS_PIN_HI_STB]
            && pad_out[EBPS_PIN_HI_STB] == $past(wr_hi_n_in)))
        else $error("high write strobe not on pin");
    high_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(ext_bus && bus16 && mode_q[EBPS_MODE_HI_OE]) |=> (pad_out[EBPS_PIN_HI_STB] == $past(port_data_q[EBPS_PIN_HI_STB])
            && pad_oe_n[EBPS_PIN_HI_STB] == !$past(port_dir_q[EBPS_PIN_HI_STB])))
        else $error("high strobe pin not port");
    // ========================================
    // byte lanes
    lane_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_lane_we[1] |-> $past(bus16 && !wr_hi_n_in))
        else $error("high lane written without 16-bit strobe");
    lane_low_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_lane_we[0] |-> $past(ext_bus && mode_q[EBPS_MODE_LO_OE] && !wr_lo_n_in))
        else $error("low lane written without low strobe");
    lane_low_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && mode_q[EBPS_MODE_LO_OE] && bus_write && !wr_lo_n_in) |=> byte_lane_we[0])
        else $error("low lane write missed");
    lane_high_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_bus && bus16 && mode_q[EBPS_MODE_HI_OE] && bus_word && bus_write && !wr_hi_n_in) |=> byte_lane_we[1])
        else $error("high lane write missed");
    lane_narrow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !bus16 |=> !byte_lane_we[1])
        else $error("high lane written on 8-bit bus");
    // ========================================
    // pull-up, input gating and switchover
    standby_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        standby |=> (port_in == '0))
        else $error("input seen in standby");
    standby_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        !standby |=> (port_in == $past(pad_in)))
        else $error("input lost outside standby");
    pull_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pull_sel_q[EBPS_PIN_RD] && !bus_sel[EBPS_PIN_RD] && !port_dir_q[EBPS_PIN_RD]) |=> pad_pull[EBPS_PIN_RD])
        else $error("pull-up not applied");
    pull_port2_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pull_sel_q[1] && !bus_sel[1] && !port_dir_q[1]) |=> pad_pull[1])
        else $error("port2 pull-up not applied");
    pull_off_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        (port_dir_q[EBPS_PIN_ALE] || bus_sel[EBPS_PIN_ALE]) |=> !pad_pull[EBPS_PIN_ALE])
        else $error("pull-up on a driven pin");
    pull_none_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pull_sel_q[EBPS_PIN_LO_STB] |=> !pad_pull[EBPS_PIN_LO_STB])
        else $error("pull-up without its select bit");
    switch_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(bus_sel[EBPS_PIN_ALE]) |=> (pad_oe_n[EBPS_PIN_ALE] == !$past(port_dir_q[EBPS_PIN_ALE])))
        else $error("switchover not to port logic");
    switch_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(bus_sel[EBPS_PIN_LO_STB]) |=> (pad_out[EBPS_PIN_LO_STB] == $past(port_data_q[EBPS_PIN_LO_STB])))
        else $error("low strobe switchover not to port data");
    switch_to_bus_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bus_sel[EBPS_PIN_RD]) |=> (!pad_oe_n[EBPS_PIN_RD] && pad_out[EBPS_PIN_RD] == $past(rd_n_in)))
        else $error("switchover not to read strobe");
    // ========================================
    // register bus answer
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past access phase");
    slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");
    read_idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> (prdata == EBPS_RD_ZERO))
        else $error("read data outside answer");
endmodule : ebps_top

// >>> verif/ebps_ext_bus_model.sv
// far side of the shared pins: resolves each pad level
module ebps_ext_bus_model (
    // clock
    input wire logic pclk,
    // device pads
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pull,
    // external drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] flt_q = 8'h00;
    // a floating pad must not hold its last value, so it toggles every cycle
    always @(posedge pclk) flt_q <= ~flt_q;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else begin
                pad_in[i] = pad_pull[i] | flt_q[i];
            end
        end
    end
endmodule : ebps_ext_bus_model

// >>> verif/external_bus_pin_select_test.sv
// self-checking bench for the external bus pin select block
module external_bus_pin_select_test
    import ebps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // stimulus and observation
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rdat;
    logic pready, pslverr, serr;
    logic [3:0] hao = 4'hC;
    logic ale = 1'b0, rd_n = 1'b1, lo_wr_n = 1'b1, hi_wr_n = 1'b1, bwr = 1'b0, bword = 1'b0;
    logic [7:0] pad_in, pad_out, pad_oe_n, pad_pull, port_in, ext_en = 8'h00, ext_val = 8'h00;
    logic [1:0] blwe;
    int miscompares = 0, num_checks = 0;
    always #50 pclk = ~pclk;
    ebps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .high_address_outputs(hao), .ale_in(ale), .rd_n_in(rd_n), .wr_lo_n_in(lo_wr_n),
        .wr_hi_n_in(hi_wr_n), .bus_write(bwr), .bus_word(bword), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_pull(pad_pull), .port_in(port_in), .byte_lane_we(blwe));
    ebps_ext_bus_model far (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pull(pad_pull), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    // ========================================
    // tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // one apb transfer; an idle edge first keeps back-to-back calls from double driving
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rdat[7:0], exp);
    endtask : rd
    // pads are registered: let selection and sources land
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle
    // ========================================
    // sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(pad_out, 8'hFF);
        chk(pad_oe_n, 8'hFF);
        rd(EBPS_OFF_HADDR, 8'h00);
        rd(EBPS_OFF_MODE, 8'h00);
        apb(1'b1, EBPS_OFF_PDAT, 32'h000000A5);
        apb(1'b1, EBPS_OFF_PDIR, 32'h000000FF);
        settle();
        chk(pad_oe_n, 8'h00);
        chk(pad_out, 8'hA5);
        rd(EBPS_OFF_STAT, 8'h00);
        apb(1'b1, EBPS_OFF_MODE, 32'h00000001);
        @(posedge pclk);
        ale <= 1'b1;
        rd_n <= 1'b0;
        settle();
        chk(pad_out, 8'h9C);
        rd(EBPS_OFF_STAT, 8'h3F);
        apb(1'b1, EBPS_OFF_PDIR, 32'h00000000);
        apb(1'b1, EBPS_OFF_HADDR, 32'h0000000A);
        apb(1'b1, EBPS_OFF_PULL, 32'h000000FF);
        settle();
        chk(pad_oe_n, 8'hCA);
        chk(pad_pull, 8'hCA);
        apb(1'b1, EBPS_OFF_MODE, 32'h0000000D);
        @(posedge pclk);
        lo_wr_n <= 1'b0;
        hi_wr_n <= 1'b0;
        hao <= 4'h3;
        settle();
        chk(pad_oe_n, 8'h8A);
        chk({7'h00, pad_out[6]}, 8'h00);
        chk({4'h0, pad_out[3:0]}, 8'h01);
        apb(1'b1, EBPS_OFF_MODE, 32'h0000000F);
        settle();
        chk(pad_oe_n, 8'h0A);
        chk({6'h00, pad_out[7:6]}, 8'h00);
        @(posedge pclk);
        bwr <= 1'b1;
        hi_wr_n <= 1'b1;
        settle();
        chk({6'h00, blwe}, 8'h01);
        @(posedge pclk);
        bword <= 1'b1;
        hi_wr_n <= 1'b0;
        settle();
        chk({6'h00, blwe}, 8'h03);
        @(posedge pclk);
        lo_wr_n <= 1'b1;
        settle();
        chk({6'h00, blwe}, 8'h02);
        // 8-bit bus: the low strobe alone writes, even for a word request
        apb(1'b1, EBPS_OFF_MODE, 32'h0000000D);
        lo_wr_n <= 1'b0;
        settle();
        chk({6'h00, blwe}, 8'h01);
        apb(1'b1, EBPS_OFF_MODE, 32'h00000003);
        settle();
        chk(pad_oe_n, 8'hCA);
        chk({6'h00, blwe}, 8'h00);
        @(posedge pclk);
        ext_en <= 8'hFF;
        ext_val <= 8'h5A;
        apb(1'b1, EBPS_OFF_MODE, 32'h00000000);
        settle();
        chk(port_in, 8'h5A);
        rd(EBPS_OFF_PIN, 8'h5A);
        apb(1'b1, EBPS_OFF_MODE, 32'h00000010);
        settle();
        chk(port_in, 8'h00);
        rd(EBPS_OFF_PIN, 8'h00);
        rd(8'h40, 8'h00);
        chk({7'h00, serr}, 8'h01);
        end_sim();
    end
endmodule : external_bus_pin_select_test
